// ==== logic/sram_ctrl.sv ====
`timescale 1ns/10ps
// How it works
// - Write spans overlap; first rise ends it
// - Hold write data around ending edge
// - Address held 35 ns per cycle
// - Write strobe low at least 30 ns
// - Select low 30 ns before write end
// - Address stable across strobe, zero setup/hold
// - Address stable 30 ns before write end
module sram_ctrl
	import sram_ctrl_pkg::*;
#(
	parameter int unsigned AW           = ADDR_W,
	parameter int unsigned DW           = DATA_W,
	parameter int unsigned READ_CYC     = READ_CYCLES,
	parameter int unsigned WRITE_CYC    = WRITE_CYCLES,
	parameter int unsigned FLOAT_CYC    = FLOAT_CYCLES,
	parameter int unsigned HOLD_CYC     = HOLD_CYCLES,
	parameter int unsigned DESEL_CYC    = DESEL_CYCLES,
	parameter bit          STAY_SELECTED = 1'b0
) (
	input  wire logic          clock_in,
	input  wire logic          reset_in,
	// User request side
	input  wire logic          req_valid_in,
	input  wire logic          req_write_in,
	input  wire logic [AW-1:0] req_addr_in,
	input  wire logic [DW-1:0] req_wdata_in,
	output logic               req_ready_out,
	output logic               rd_valid_out,
	output logic [DW-1:0]      rd_data_out,
	// Memory pins
	output logic [AW-1:0]      word_address_out,
	output logic               select_n_out,
	output logic               write_strobe_n_out,
	input  wire logic [DW-1:0] data_lines_in,
	output logic [DW-1:0]      data_lines_out,
	output logic               data_lines_oe_n_out
);

	localparam int unsigned CW      = 8;
	localparam int unsigned CNT_MAX = (1 << CW) - 1;

	// Elaboration checks: pins match the memory, phase counts at least one and within the timer width
	if (AW != ADDR_W || DW != DATA_W) begin : g_bad_pins
		$error("sram_ctrl: pin widths must match the memory");
	end
	if (READ_CYC < 1 || WRITE_CYC < 1 || FLOAT_CYC < 1 || HOLD_CYC < 1 || DESEL_CYC < 1) begin : g_bad_short
		$error("sram_ctrl: phase counts must be at least one");
	end
	if (READ_CYC + SYNC_EXTRA_CYCLES > CNT_MAX || WRITE_CYC > CNT_MAX || DESEL_CYC > CNT_MAX
		|| FLOAT_CYC > CNT_MAX || HOLD_CYC > CNT_MAX) begin : g_bad_long
		$error("sram_ctrl: phase counts exceed timer width");
	end

	ctrl_state_t     state_r;
	ctrl_state_t     state_nxt;
	logic [AW-1:0]   addr_r;
	logic [DW-1:0]   wdata_r;
	logic [DW-1:0]   rd_data_r;
	logic            rd_valid_r;
	logic            select_n_r;
	logic            strobe_n_r;
	logic            drive_r;
	logic            timer_load;
	logic [CW-1:0]   timer_count;
	logic            timer_done;
	logic [DW-1:0]   sync1_r;
	logic [DW-1:0]   sync2_r;
	logic [DW-1:0]   sync3_r;

	// Phase timer shared by all states
	sram_phase_timer #(
		.CNT_W (CW)
	) u_timer (
		.clock_in (clock_in),
		.reset_in (reset_in),
		.load_in  (timer_load),
		.count_in (timer_count),
		.done_out (timer_done)
	);

	// Data pins come from outside the clock domain: three flops
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
		end else begin
			sync1_r <= data_lines_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	// States that may take a new request once their timer has run out
	function automatic logic accepts_req(input ctrl_state_t s);
		return (s == ST_IDLE) || (s == ST_DESEL);
	endfunction

	wire           take_req   = accepts_req(state_r) && timer_done && req_valid_in;
	wire           read_stable = (sync2_r == sync3_r);
	wire [CW-1:0]  read_count  = CW'(READ_CYC + SYNC_EXTRA_CYCLES); // Extra cycles cover the synchroniser
	wire [CW-1:0]  write_count = CW'(WRITE_CYC);
	wire [CW-1:0]  float_count = CW'(FLOAT_CYC);
	wire [CW-1:0]  hold_count  = CW'(HOLD_CYC);
	wire [CW-1:0]  desel_count = CW'(DESEL_CYC);

	// Pin levels decode the next state, so each pin moves with its state
	wire           select_n_nxt = !(state_nxt == ST_READ || state_nxt == ST_FLOAT || state_nxt == ST_WRITE
		|| state_nxt == ST_HOLD || (STAY_SELECTED && state_nxt == ST_IDLE));
	wire           strobe_n_nxt = !(state_nxt == ST_FLOAT || state_nxt == ST_WRITE);
	wire           drive_nxt    = (state_nxt == ST_WRITE || state_nxt == ST_HOLD);

	// Next state and timer loads
	always_comb begin
		state_nxt   = state_r;
		timer_load  = 1'b0;
		timer_count = COUNT_ZERO;
		unique case (state_r)
			ST_IDLE, ST_DESEL: begin
				if (take_req) begin
					timer_load = 1'b1;
					if (req_write_in) begin
						state_nxt   = ST_FLOAT;  // Let memory float before we drive
						timer_count = float_count;
					end else begin
						state_nxt   = ST_READ;
						timer_count = read_count;
					end
				end else if (state_r == ST_DESEL && timer_done) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_READ: begin
				if (timer_done && read_stable) begin
					state_nxt   = ST_DESEL;
					timer_load  = 1'b1;
					timer_count = desel_count;
				end
			end
			ST_FLOAT: begin
				if (timer_done) begin
					state_nxt   = ST_WRITE;
					timer_load  = 1'b1;
					timer_count = write_count;
				end
			end
			ST_WRITE: begin
				if (timer_done) begin
					state_nxt   = ST_HOLD;
					timer_load  = 1'b1;
					timer_count = hold_count;
				end
			end
			ST_HOLD: begin
				if (timer_done) begin
					state_nxt   = ST_DESEL;
					timer_load  = 1'b1;
					timer_count = desel_count;
				end
			end
			default: state_nxt = ST_IDLE;
		endcase
	end

	// State, latched request and pin registers
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			state_r    <= ST_IDLE;
			addr_r     <= '0;
			wdata_r    <= '0;
			select_n_r <= 1'b1;
			strobe_n_r <= 1'b1;
			drive_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (take_req) begin
				addr_r  <= req_addr_in; // Address held the whole cycle
				wdata_r <= req_wdata_in;
			end
			// Select low for every access; optionally also low in idle, but always high in the deselect phase
			select_n_r <= select_n_nxt;
			strobe_n_r <= strobe_n_nxt; // Overlap with select
			drive_r    <= drive_nxt; // Strobe rises first, data held
		end
	end

	// Capture read word once the synchroniser has settled
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			rd_data_r  <= '0;
			rd_valid_r <= 1'b0;
		end else begin
			rd_valid_r <= 1'b0;
			if (state_r == ST_READ && timer_done && read_stable) begin
				rd_data_r  <= sync3_r; // Same polarity as written
				rd_valid_r <= 1'b1;
			end
		end
	end

	assign req_ready_out       = accepts_req(state_r) && timer_done;
	assign rd_valid_out        = rd_valid_r;
	assign rd_data_out         = rd_data_r;
	assign word_address_out    = addr_r;
	assign select_n_out        = select_n_r;
	assign write_strobe_n_out  = strobe_n_r;
	assign data_lines_out      = wdata_r;
	assign data_lines_oe_n_out = !drive_r; // Drive in the write and hold phases, after the float phase

endmodule // sram_ctrl

// ==== logic/sram_ctrl_pkg.sv ====
package sram_ctrl_pkg;

	// Pin widths of the attached memory
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 4;
	localparam int unsigned WORDS  = 4096;

	// Clock period in ps
	localparam int unsigned CLK_PERIOD_PS = 8000;

	// Fastest-grade timing figures in ns
	localparam int unsigned READ_CYCLE_MIN_NS           = 35;
	localparam int unsigned SELECT_ACCESS_DELAY_NS      = 35;
	localparam int unsigned DESELECT_FLOAT_DELAY_NS     = 20;
	localparam int unsigned WRITE_FLOAT_DELAY_NS        = 15;
	localparam int unsigned WRITE_PULSE_MIN_NS          = 30;
	localparam int unsigned SELECT_TO_WRITE_END_MIN_NS  = 30;
	localparam int unsigned ADDRESS_TO_WRITE_END_MIN_NS = 30;
	localparam int unsigned DATA_SETUP_MIN_NS           = 20;
	localparam int unsigned DATA_HOLD_MIN_NS            = 5;
	localparam int unsigned ADDRESS_SETUP_MIN_NS        = 0;
	localparam int unsigned ADDRESS_HOLD_AFTER_WRITE_NS = 0;
	localparam int unsigned STANDBY_ENTRY_DELAY_NS      = 35;
	localparam int unsigned STANDBY_EXIT_DELAY_NS       = 0;

	// Least times round up to whole cycles, never below one
	function automatic int unsigned ns_to_cycles_min(input int unsigned ns);
		int unsigned c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int unsigned READ_CYCLES  = ns_to_cycles_min(READ_CYCLE_MIN_NS);
	localparam int unsigned WRITE_CYCLES = ns_to_cycles_min(WRITE_PULSE_MIN_NS);
	localparam int unsigned FLOAT_CYCLES = ns_to_cycles_min(WRITE_FLOAT_DELAY_NS);
	localparam int unsigned HOLD_CYCLES  = ns_to_cycles_min(DATA_HOLD_MIN_NS);
	localparam int unsigned DESEL_CYCLES = ns_to_cycles_min(DESELECT_FLOAT_DELAY_NS);

	// Extra read cycles while the data synchroniser fills
	localparam int unsigned SYNC_EXTRA_CYCLES = 2;

	// Controller states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_READ  = 3'b001,
		ST_FLOAT = 3'b010,
		ST_WRITE = 3'b011,
		ST_HOLD  = 3'b100,
		ST_DESEL = 3'b101
	} ctrl_state_t;

	localparam logic [7:0] COUNT_ZERO = 8'h00;

endpackage : sram_ctrl_pkg

// ==== logic/sram_phase_timer.sv ====
`timescale 1ns/10ps
// Loadable down counter marking the end of each bus phase
module sram_phase_timer
	import sram_ctrl_pkg::*;
#(
	parameter int unsigned CNT_W = 8
) (
	input  wire logic             clock_in,
	input  wire logic             reset_in,
	input  wire logic             load_in,
	input  wire logic [CNT_W-1:0] count_in,
	output logic                  done_out
);

	logic [CNT_W-1:0] count_r;

	// Elaboration check: a one-bit counter cannot hold a phase
	if (CNT_W < 2) begin : g_bad_width
		$error("sram_phase_timer: CNT_W too small");
	end

	// Load takes priority so back-to-back phases never see a stale count
	always_ff @(posedge clock_in or posedge reset_in) begin
		if (reset_in) begin
			count_r <= '0;
		end else if (load_in) begin
			count_r <= count_in;
		end else if (count_r != '0) begin
			count_r <= count_r - 1'b1;
		end
	end

	// Done looks at the count only, so the load decision never feeds back into it
	assign done_out = (count_r == '0);

endmodule // sram_phase_timer

// ==== dv/sram_ctrl_checker.sv ====
`timescale 1ns/10ps
module sram_ctrl_checker
	import sram_ctrl_pkg::*;
(
	input wire logic              clock_in,
	input wire logic              reset_in,
	input wire logic              req_ready_out,
	input wire logic              rd_valid_out,
	input wire logic [ADDR_W-1:0] word_address_out,
	input wire logic              select_n_out,
	input wire logic              write_strobe_n_out,
	input wire logic [DATA_W-1:0] data_lines_out,
	input wire logic              data_lines_oe_n_out
);
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// Bus timing in whole 8 ns cycles
	property p_strobe_sel; !write_strobe_n_out |-> !select_n_out; endproperty
	a_strobe_sel: assert property (p_strobe_sel) else $error("strobe without select");
	property p_wr_pulse; $fell(write_strobe_n_out) |-> !write_strobe_n_out [*4]; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse short");
	property p_setup; $rose(write_strobe_n_out) |-> $past(data_lines_oe_n_out, 3) == 1'b0; endproperty
	a_setup: assert property (p_setup) else $error("data setup short");
	property p_sel_end; $rose(write_strobe_n_out) |-> $past(select_n_out, 4) == 1'b0; endproperty
	a_sel_end: assert property (p_sel_end) else $error("select short before write end");
	property p_hold;
		$rose(write_strobe_n_out) |-> !data_lines_oe_n_out && $stable(data_lines_out) && $stable(word_address_out);
	endproperty
	a_hold: assert property (p_hold) else $error("hold at write end broken");
	property p_addr_wr; !write_strobe_n_out && !$fell(write_strobe_n_out) |-> $stable(word_address_out); endproperty
	a_addr_wr: assert property (p_addr_wr) else $error("address moved in write");
	property p_float; $fell(data_lines_oe_n_out) |-> $past(write_strobe_n_out, 2) == 1'b0; endproperty
	a_float: assert property (p_float) else $error("drove before memory floated");
	property p_drive_sel; !data_lines_oe_n_out |-> !select_n_out; endproperty
	a_drive_sel: assert property (p_drive_sel) else $error("drive while deselected");
	property p_rd_sel; $fell(select_n_out) && write_strobe_n_out |-> !select_n_out [*5]; endproperty
	a_rd_sel: assert property (p_rd_sel) else $error("read cycle short");
	property p_rd_time; rd_valid_out |-> $past(select_n_out, 5) == 1'b0; endproperty
	a_rd_time: assert property (p_rd_time) else $error("read sampled early");
	property p_busy; !select_n_out |-> !req_ready_out; endproperty
	a_busy: assert property (p_busy) else $error("ready while busy");
	c_write: cover property ($rose(write_strobe_n_out));
	c_read: cover property (rd_valid_out);
	c_back: cover property (rd_valid_out ##[1:20] $fell(write_strobe_n_out));
endmodule // sram_ctrl_checker

bind sram_ctrl sram_ctrl_checker chk_u (.clock_in(clock_in), .reset_in(reset_in), .req_ready_out(req_ready_out),
	.rd_valid_out(rd_valid_out), .word_address_out(word_address_out), .select_n_out(select_n_out),
	.write_strobe_n_out(write_strobe_n_out), .data_lines_out(data_lines_out),
	.data_lines_oe_n_out(data_lines_oe_n_out));

// ==== dv/sram_model.sv ====
`timescale 1ns/10ps
// Behavioural memory; resolves the shared data bus too
module sram_model
	import sram_ctrl_pkg::*;
(
	input  wire logic [ADDR_W-1:0] word_address_in,
	input  wire logic              select_n_in,
	input  wire logic              write_strobe_n_in,
	input  wire logic [DATA_W-1:0] ctrl_data_in,
	input  wire logic              ctrl_oe_n_in,
	input  wire logic              slow_in,
	output logic      [DATA_W-1:0] bus_out
);
	logic [DATA_W-1:0] mem [WORDS]; // Static store, no refresh
	logic [DATA_W-1:0] rd_q = '0;
	logic              drive;
	logic              wr_on;
	// Drive only while selected and strobe high
	assign drive = !select_n_in && write_strobe_n_in;
	assign wr_on = !select_n_in && !write_strobe_n_in;
	// Slow mode shows a wrong word until access time runs out
	// Scheduled update does not hold the block, so no address or select change is missed
	always @(word_address_in or drive) begin
		rd_q = ~rd_q;
		rd_q <= #(slow_in ? 35 : 1) mem[word_address_in];
	end
	// Capture on whichever edge ends the overlap
	always @(negedge wr_on) mem[word_address_in] = bus_out;
	// Undriven bus shows the inverse so stale values never pass
	assign bus_out = !ctrl_oe_n_in ? ctrl_data_in : (drive ? rd_q : ~rd_q);
endmodule // sram_model

// ==== dv/tb.sv ====
`timescale 1ns/10ps
module tb
	import sram_ctrl_pkg::*;
;
	logic              clock_in, reset_in, req_valid_in, req_write_in, slow;
	logic [ADDR_W-1:0] req_addr_in, word_address_out;
	logic [DATA_W-1:0] req_wdata_in, rd_data_out, data_lines_out, bus;
	logic              req_ready_out, rd_valid_out, select_n_out, write_strobe_n_out, data_lines_oe_n_out;
	int                err_count, samples_checked;
	sram_ctrl dut_u (.clock_in(clock_in), .reset_in(reset_in), .req_valid_in(req_valid_in),
		.req_write_in(req_write_in), .req_addr_in(req_addr_in), .req_wdata_in(req_wdata_in),
		.req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
		.word_address_out(word_address_out), .select_n_out(select_n_out),
		.write_strobe_n_out(write_strobe_n_out), .data_lines_in(bus), .data_lines_out(data_lines_out),
		.data_lines_oe_n_out(data_lines_oe_n_out));
	sram_model mem_u (.word_address_in(word_address_out), .select_n_in(select_n_out),
		.write_strobe_n_in(write_strobe_n_out), .ctrl_data_in(data_lines_out),
		.ctrl_oe_n_in(data_lines_oe_n_out), .slow_in(slow), .bus_out(bus));
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic finish_test();
		$display("checks=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Request held until the edge that sees ready
	task automatic req(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		int n = 0;
		@(negedge clock_in);
		req_write_in = wr;
		req_addr_in = a;
		req_wdata_in = d;
		req_valid_in = 1'b1;
		while (req_ready_out !== 1'b1 && n < 50) begin @(negedge clock_in); n++; end
		if (req_ready_out !== 1'b1) begin err_count++; finish_test(); end
		@(negedge clock_in);
		req_valid_in = 1'b0;
	endtask
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
		int n = 0;
		req(1'b0, a, 4'h0);
		while (rd_valid_out !== 1'b1 && n < 50) begin @(negedge clock_in); n++; end
		if (rd_valid_out !== 1'b1) begin err_count++; finish_test(); end
		check(rd_data_out, exp);
	endtask
	// Edge addresses and polarity patterns, back to back
	task automatic sc_write_read();
		logic [ADDR_W-1:0] a [6] = '{12'h000, 12'hfff, 12'h5a5, 12'ha5a, 12'h001, 12'h800};
		logic [DATA_W-1:0] d [6] = '{4'hf, 4'h0, 4'h5, 4'ha, 4'h1, 4'h8};
		foreach (a[i]) req(1'b1, a[i], d[i]);
		foreach (a[i]) rd(a[i], d[i]);
		req(1'b1, 12'h001, 4'h6);
		rd(12'h000, 4'hf);
		rd(12'h001, 4'h6);
	endtask
	// Reading twice leaves the word intact
	task automatic sc_reread();
		rd(12'h5a5, 4'h5);
		rd(12'h5a5, 4'h5);
	endtask
	// Memory at its slowest legal access
	task automatic sc_slow();
		slow = 1'b1;
		req(1'b1, 12'h333, 4'hc);
		rd(12'h333, 4'hc);
		rd(12'hfff, 4'h0);
		slow = 1'b0;
	endtask
	// Bus released between accesses
	task automatic sc_idle();
		repeat (6) @(negedge clock_in);
		check({3'h0, select_n_out}, 4'h1);
		check({3'h0, data_lines_oe_n_out}, 4'h1);
		check({3'h0, write_strobe_n_out}, 4'h1);
	endtask
	initial begin
		reset_in = 1'b1;
		req_valid_in = 1'b0;
		req_write_in = 1'b0;
		req_addr_in = '0;
		req_wdata_in = '0;
		slow = 1'b0;
		err_count = 0;
		samples_checked = 0;
		repeat (4) @(negedge clock_in);
		reset_in = 1'b0;
		sc_write_read();
		sc_reread();
		sc_slow();
		sc_idle();
		finish_test();
	end
endmodule // tb
